// [src/vcav_regs.vh]
// Register indices, field positions and reset values of the row pitch,
// address mode and vertical blanking register group.
// Assumes the index/data port decode sits beside these registers.
`ifndef VCAV_REGS_VH
`define VCAV_REGS_VH

`define VCAV_IDX_ROW_PITCH      8'h13
`define VCAV_IDX_UL_MODE        8'h14
`define VCAV_IDX_VB_START_LOW   8'h15
`define VCAV_IDX_VB_END         8'h16
`define VCAV_IDX_CRT_MODE       8'h17

`define VCAV_UL_DWORD_BIT       6
`define VCAV_UL_CNT4_BIT        5
`define VCAV_UL_LOC_MSB         4
`define VCAV_UL_WMASK           8'h7f

`define VCAV_CM_RESET_BIT       7
`define VCAV_CM_WORDBYTE_BIT    6
`define VCAV_CM_WRAP_BIT        5
`define VCAV_CM_CNT2_BIT        3
`define VCAV_CM_WMASK           8'hef

`define VCAV_MSL_VBS9_BIT       5
`define VCAV_OVF_VBS8_BIT       3

`define VCAV_RST_BYTE           8'h00
`define VCAV_RST_CRT_MODE       8'h80

`define VCAV_MODE_BYTE          3'b001
`define VCAV_MODE_WORD          3'b010
`define VCAV_MODE_DWORD         3'b100

`endif

// [src/vcav_ctrl.v]
// Row pitch, addressing mode, counter interval, underline, vertical blanking
// and controller reset logic of the CRT controller, on the character clock.
// Assumes the index port holds the register index and the timing counters
// and sync generators are on the same clock.
//
// Behaviour
// - Row pitch gives memory per character row, in words or doublewords.
// - Reserved underline bit 7 and mode control bit 4 read zero.
// - Doubleword bit wins; both zero means word; word/byte alone means byte.
// - Counter address unshifted in byte, shifted one in word, two in doubleword.
// - Counter advance every 1, 2, 4 or 2 character clocks by count bits.
// - Underline drawn in text mode only, on the 5-bit selected pixel line, top line zero.
// - Blanking start is 10 bits from start register, scan line and overflow.
// - Blanking begins on the scan line equal to the 10-bit start.
// - Blanking ends when low 8 bits of scan-line count equal end value.
// - Reset bit zero forces syncs inactive and touches nothing else.
// - Reset bit acts only in native non-centered modes.
// - Word mode wraps at 16 KB when wrap bit is zero.
// - Word mode output bit 0 takes counter bit 15 or bit 13.
`timescale 1ns/1ps
`include "vcav_regs.vh"

module vcav_ctrl (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire [7:0]  reg_index,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    input  wire        char_clk_en,
    input  wire        ma_load,
    input  wire [15:0] ma_start,
    input  wire [9:0]  scan_line,
    input  wire [4:0]  char_row_line,
    input  wire        text_mode,
    input  wire [7:0]  maximum_scan_line,
    input  wire [7:0]  timing_overflow,
    input  wire        sequencer_clocking_mode,
    input  wire        native_noncentered,
    input  wire        hsync_in,
    input  wire        vsync_in,
    input  wire        hsync_idle,
    input  wire        vsync_idle,
    output reg  [15:0] fb_addr,
    output reg  [15:0] ma_count,
    output reg  [7:0]  row_pitch_out,
    output reg         row_pitch_dword,
    output reg  [2:0]  addr_mode,
    output reg         underline_on,
    output reg         vblank,
    output reg         hsync_out,
    output reg         vsync_out
);

    reg [7:0]  row_pitch_q;
    reg [7:0]  ul_mode_q;
    reg [7:0]  vb_start_low_q;
    reg [7:0]  vb_end_q;
    reg [7:0]  crt_mode_q;
    reg [1:0]  div_q;
    reg [15:0] ma_q;
    reg        vblank_q;
    reg [1:0]  div_d;
    reg [15:0] ma_d;
    reg        vblank_d;
    reg [15:0] fb_addr_d;

    wire [9:0] vb_start;
    wire [2:0] mode;
    wire [1:0] interval_m1;
    wire       sync_hold;
    wire       ma_step;
    wire       ul_line_hit;

    // Mode decode, shared by address shaping and status outputs
    function [2:0] mode_of;
        input dword;
        input word_byte;
        begin
            if (dword)
                mode_of = `VCAV_MODE_DWORD;
            else if (word_byte)
                mode_of = `VCAV_MODE_BYTE;
            else
                mode_of = `VCAV_MODE_WORD;
        end
    endfunction

    assign mode = mode_of(ul_mode_q[`VCAV_UL_DWORD_BIT], crt_mode_q[`VCAV_CM_WORDBYTE_BIT]);

    // Count-by-2 dominates count-by-4
    assign interval_m1 = crt_mode_q[`VCAV_CM_CNT2_BIT] ? 2'd1 :
                         (ul_mode_q[`VCAV_UL_CNT4_BIT] ? 2'd3 : 2'd0);
    assign ma_step     = char_clk_en && (div_q == interval_m1);

    assign vb_start = {maximum_scan_line[`VCAV_MSL_VBS9_BIT],
                       timing_overflow[`VCAV_OVF_VBS8_BIT], vb_start_low_q};

    assign sync_hold = native_noncentered && !crt_mode_q[`VCAV_CM_RESET_BIT];

    // Register writes through the indexed data port
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            row_pitch_q    <= `VCAV_RST_BYTE;
            ul_mode_q      <= `VCAV_RST_BYTE;
            vb_start_low_q <= `VCAV_RST_BYTE;
            vb_end_q       <= `VCAV_RST_BYTE;
            crt_mode_q     <= `VCAV_RST_CRT_MODE;
        end else if (clk_en && reg_wr) begin
            case (reg_index)
                `VCAV_IDX_ROW_PITCH:    row_pitch_q    <= reg_wdata;
                `VCAV_IDX_UL_MODE:      ul_mode_q      <= reg_wdata & `VCAV_UL_WMASK;
                `VCAV_IDX_VB_START_LOW: vb_start_low_q <= reg_wdata;
                `VCAV_IDX_VB_END:       vb_end_q       <= reg_wdata;
                `VCAV_IDX_CRT_MODE:     crt_mode_q     <= reg_wdata & `VCAV_CM_WMASK;
                default: begin
                end
            endcase
        end
    end

    // Read-back; unknown indices read zero
    always @* begin
        case (reg_index)
            `VCAV_IDX_ROW_PITCH:    reg_rdata = row_pitch_q;
            `VCAV_IDX_UL_MODE:      reg_rdata = ul_mode_q & `VCAV_UL_WMASK;
            `VCAV_IDX_VB_START_LOW: reg_rdata = vb_start_low_q;
            `VCAV_IDX_VB_END:       reg_rdata = vb_end_q;
            `VCAV_IDX_CRT_MODE:     reg_rdata = crt_mode_q & `VCAV_CM_WMASK;
            default:                reg_rdata = 8'h00;
        endcase
    end

    // Counter next value; a load restarts the divider so the first step
    // lands one full interval after it
    always @* begin
        div_d = div_q;
        ma_d  = ma_q;
        if (ma_load) begin
            div_d = 2'd0;
            ma_d  = ma_start;
        end else if (char_clk_en) begin
            // Divider restarts when the interval shrinks below it
            div_d = (div_q >= interval_m1) ? 2'd0 : div_q + 2'd1;
            if (ma_step)
                ma_d = ma_q + 16'h0001;
        end
    end

    // Memory address counter with interval divider
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 2'd0;
            ma_q  <= 16'h0000;
        end else if (clk_en) begin
            div_q <= div_d;
            ma_q  <= ma_d;
        end
    end

    // Blanking: start on full 10-bit match, end on low 8 bits; start is
    // tested first so a start and end on one line leaves blanking on
    always @* begin
        vblank_d = vblank_q;
        if (scan_line == vb_start)
            vblank_d = 1'b1;
        else if (scan_line[7:0] == vb_end_q)
            vblank_d = 1'b0;
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            vblank_q <= 1'b0;
        else if (clk_en)
            vblank_q <= vblank_d;
    end

    // Address shaping toward the frame buffer decoder
    always @* begin
        case (mode)
            `VCAV_MODE_BYTE:  fb_addr_d = ma_q;
            `VCAV_MODE_DWORD: fb_addr_d = {ma_q[13:0], ma_q[15:14]};
            `VCAV_MODE_WORD: begin
                // Wrap bit only matters here; 16 KB wrap feeds bit 13 back
                if (crt_mode_q[`VCAV_CM_WRAP_BIT])
                    fb_addr_d = {ma_q[14:0], ma_q[15]};
                else
                    fb_addr_d = {ma_q[14:0], ma_q[13]};
            end
            default:          fb_addr_d = ma_q;
        endcase
    end

    assign ul_line_hit = text_mode && (char_row_line == ul_mode_q[`VCAV_UL_LOC_MSB:0]);

    // Registered outputs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fb_addr         <= 16'h0000;
            ma_count        <= 16'h0000;
            row_pitch_out   <= 8'h00;
            row_pitch_dword <= 1'b0;
            addr_mode       <= `VCAV_MODE_WORD;
            underline_on    <= 1'b0;
            vblank          <= 1'b0;
            hsync_out       <= 1'b0;
            vsync_out       <= 1'b0;
        end else if (clk_en) begin
            fb_addr         <= fb_addr_d;
            ma_count        <= ma_q;
            row_pitch_out   <= row_pitch_q;
            row_pitch_dword <= sequencer_clocking_mode;
            addr_mode       <= mode;
            underline_on    <= ul_line_hit;
            vblank          <= vblank_q;
            // Sync forced idle only; all else keeps running
            hsync_out       <= sync_hold ? hsync_idle : hsync_in;
            vsync_out       <= sync_hold ? vsync_idle : vsync_in;
        end
    end

endmodule

// [verification/vcav_ctrl_sva.sv]
// Port checks of vcav_ctrl: reserved bits, mode, sync hold, underline.
// Assumes bind into vcav_ctrl, one clock, clk_en as the only enable.
`timescale 1ns/1ps
module vcav_ctrl_sva (
    input wire       clk,
    input wire       arst_n,
    input wire       clk_en,
    input wire [7:0] reg_index,
    input wire [7:0] reg_rdata,
    input wire       text_mode,
    input wire [4:0] char_row_line,
    input wire       underline_on,
    input wire       native_noncentered,
    input wire       hsync_in,
    input wire       vsync_in,
    input wire       hsync_idle,
    input wire       hsync_out,
    input wire       vsync_idle,
    input wire       vsync_out,
    input wire [2:0] addr_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Register value seen through the read port, so index must be parked
    wire hold   = clk_en && native_noncentered && reg_index == 8'h17 && !reg_rdata[7];
    wire ul_hit = text_mode && char_row_line == reg_rdata[4:0];
    AST_UL_RSV: assert property (reg_index == 8'h14 |-> !reg_rdata[7]) else $error("bit 7 not zero");
    AST_CM_RSV: assert property (reg_index == 8'h17 |-> !reg_rdata[4]) else $error("bit 4 not zero");
    AST_UNMAPPED: assert property ((reg_index < 8'h13 || reg_index > 8'h17) |-> reg_rdata == 8'h00)
        else $error("unmapped index not zero");
    AST_DWORD: assert property (clk_en && reg_index == 8'h14 && reg_rdata[6] |=> addr_mode == 3'b100)
        else $error("dword mode not taken");
    AST_HS_HOLD: assert property (hold |=> hsync_out == $past(hsync_idle)) else $error("hsync not idle");
    AST_VS_HOLD: assert property (hold |=> vsync_out == $past(vsync_idle)) else $error("vsync not idle");
    AST_NON_NATIVE: assert property (clk_en && !native_noncentered |=> hsync_out == $past(hsync_in))
        else $error("hsync held outside native mode");
    AST_VS_PASS: assert property (clk_en && !native_noncentered |=> vsync_out == $past(vsync_in))
        else $error("vsync held outside native mode");
    AST_UL_ON: assert property (clk_en && reg_index == 8'h14 |=> underline_on == $past(ul_hit))
        else $error("underline line wrong");
endmodule

bind vcav_ctrl vcav_ctrl_sva u_sva (.*);

// [verification/vcav_disp_model.sv]
// Sync source standing in for the timing generators.
// Assumes the controller clock; short periods so edges come often.
`timescale 1ns/1ps
module vcav_disp_model (
    input  wire clk,
    input  wire arst_n,
    output wire hsync_in,
    output wire vsync_in
);
    reg [7:0] cnt_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end
    assign hsync_in = cnt_q[2:0] == 3'h7;
    assign vsync_in = cnt_q[7:5] == 3'h7;
endmodule

// [verification/testbench.sv]
// Self-checking bench of vcav_ctrl with a sync source model.
// Assumes the checker is bound; inputs change on the falling edge.
`timescale 1ns/1ps
module testbench;
    reg clk = 0, arst_n = 0, clk_en = 1, reg_wr = 0, char_clk_en = 0, ma_load = 0, text_mode = 0, probe = 0;
    reg native_noncentered = 0, hsync_idle = 0, vsync_idle = 0, sequencer_clocking_mode = 0;
    reg [7:0] reg_index = 0, reg_wdata = 0, maximum_scan_line = 0, timing_overflow = 0, msk;
    reg [15:0] ma_start = 0, m, f, exp_q[$];
    reg [9:0] scan_line = 0;
    reg [4:0] char_row_line = 0;
    reg [2:0] sel = 0;
    wire [7:0] reg_rdata, row_pitch_out;
    wire [15:0] fb_addr, ma_count;
    wire [2:0] addr_mode;
    wire underline_on, vblank, hsync_out, vsync_out, row_pitch_dword, hsync_in, vsync_in;
    integer failures = 0, n_compared = 0, seed = 32'hbceeb997, i, k;
    wire [15:0] obs = sel == 0 ? reg_rdata : sel == 1 ? addr_mode : sel == 2 ? vblank : sel == 3 ? ma_count
                    : sel == 4 ? {row_pitch_dword, row_pitch_out} : sel == 5 ? fb_addr : fb_addr & 16'hfffc;
    vcav_ctrl dut (.*);
    vcav_disp_model u_disp (.*);
    initial forever #2.5 clk = ~clk;
    // Background noise on the levels that the checker watches
    always @(negedge clk) begin
        text_mode <= $random(seed);
        char_row_line <= $random(seed) & 3;
        native_noncentered <= $random(seed);
        hsync_idle <= $random(seed);
        vsync_idle <= $random(seed);
    end
    always @(posedge clk) if (probe) chk(obs);
    function [79:0] sel_name(input [2:0] s);
        case (s)
            3'd0: sel_name = "reg_rdata";
            3'd1: sel_name = "addr_mode";
            3'd2: sel_name = "vblank";
            3'd3: sel_name = "ma_count";
            3'd4: sel_name = "row_pitch";
            default: sel_name = "fb_addr";
        endcase
    endfunction
    task chk(input [15:0] got);
        reg [15:0] e;
        e = exp_q.pop_front();
        n_compared = n_compared + 1;
        if (got !== e) begin
            failures = failures + 1;
            $display("[FAIL] %0s expected %h seen %h", sel_name(sel), e, got);
        end
    endtask
    // Two idle edges first: register then output flop
    task expv(input [2:0] s, input [15:0] e);
        repeat (2) @(negedge clk);
        sel = s;
        exp_q.push_back(e);
        probe = 1;
        @(negedge clk);
        probe = 0;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        reg_index = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task rd(input [7:0] a, input [15:0] e);
        @(negedge clk);
        reg_index = a;
        expv(0, e);
    endtask
    task vb(input [9:0] s, input e);
        scan_line = s;
        expv(2, {15'h0000, e});
    endtask
    task give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        failures = failures + 1;
        give_verdict;
    end
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1;
        for (i = 8'h12; i < 8'h19; i = i + 1) rd(i[7:0], i == 8'h17 ? 16'h0080 : 16'h0000);
        $display("Test reset values done");
        for (i = 8'h13; i < 8'h19; i = i + 1) begin
            k = $random(seed);
            wr(i[7:0], k[7:0]);
            msk = i == 8'h18 ? 8'h00 : i == 8'h14 ? 8'h7f : i == 8'h17 ? 8'hef : 8'hff;
            rd(i[7:0], {8'h00, k[7:0] & msk});
        end
        sequencer_clocking_mode = 1;
        wr(8'h13, 8'h5a);
        expv(4, 16'h015a);
        // A write while the enable is low must not land
        clk_en = 0;
        wr(8'h13, 8'ha5);
        clk_en = 1;
        expv(4, 16'h015a);
        $display("Test register access done");
        for (k = 0; k < 8; k = k + 1) begin
            wr(8'h14, {1'b0, k[2], k[0], 5'h02});
            wr(8'h17, {1'b1, k[1], k[0], 1'b0, k[1], 3'h0});
            expv(1, k[2] ? 3'b100 : k[1] ? 3'b001 : 3'b010);
            @(negedge clk);
            ma_start = $random(seed);
            ma_load = 1;
            @(negedge clk);
            ma_load = 0;
            char_clk_en = 1;
            repeat (8) @(negedge clk);
            char_clk_en = 0;
            m = ma_start + 16'h8 / (k[1] ? 2 : k[0] ? 4 : 1);
            expv(3, m);
            f = k[2] ? {m[13:0], 2'b00} : k[1] ? m : {m[14:0], k[0] ? m[15] : m[13]};
            expv(k[2] ? 3'h6 : 3'h5, f);
        end
        $display("Test address modes done");
        maximum_scan_line = 8'h20;
        timing_overflow = 8'h08;
        wr(8'h15, 8'h05);
        wr(8'h16, 8'h09);
        // End match first, so blanking left over from random values is cleared
        vb(10'h109, 1'b0);
        vb(10'h105, 1'b0);
        vb(10'h205, 1'b0);
        vb(10'h305, 1'b1);
        vb(10'h306, 1'b1);
        vb(10'h009, 1'b0);
        $display("Test vertical blanking done");
        // Parked indices let the checker see the register values
        wr(8'h17, 8'h00);
        repeat (40) @(negedge clk);
        wr(8'h14, 8'h42);
        repeat (40) @(negedge clk);
        $display("Test sync hold and underline done");
        give_verdict;
    end
endmodule
